// ===== design/rdcc_pkg.sv
// Package of constants and types for the redriver configuration control block
package rdcc_pkg;
    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int RDCC_CHANNELS = 32;
    localparam int RDCC_BANKS = 4;
    localparam int RDCC_BANK_LANES = 8;
    localparam int RDCC_EQ_W = 5;
    localparam int RDCC_GAIN_W = 3;
    localparam int RDCC_PROF_W = 4;
    localparam int RDCC_LVL_W = 3;
    localparam int RDCC_ADDR_W = 8;
    localparam int RDCC_CFG_W = 12;

    // ------------------------------------------------------------------
    // Equalization index and codes
    // ------------------------------------------------------------------
    localparam logic [4:0] RDCC_EQ_MAX = 5'h13;
    localparam logic [4:0] RDCC_EQ_HOLE_LO = 5'h03;
    localparam logic [4:0] RDCC_EQ_HOLE_HI = 5'h04;
    // Power-on default: boost of index 5 with its own profile, not in the index list
    localparam logic [4:0] RDCC_EQ_DEFAULT = 5'h1F;
    localparam logic [4:0] RDCC_EQ_DEF_BOOST = 5'h05;

    // ------------------------------------------------------------------
    // Flat gain codes
    // ------------------------------------------------------------------
    localparam logic [2:0] RDCC_GAIN_M6 = 3'h0;
    localparam logic [2:0] RDCC_GAIN_M4 = 3'h1;
    localparam logic [2:0] RDCC_GAIN_M2 = 3'h3;
    localparam logic [2:0] RDCC_GAIN_0 = 3'h5;
    localparam logic [2:0] RDCC_GAIN_P2 = 3'h7;
    localparam logic [2:0] RDCC_GAIN_RESET = RDCC_GAIN_0;

    // ------------------------------------------------------------------
    // Shared registers
    // ------------------------------------------------------------------
    localparam logic [7:0] RDCC_REG_EQ_PROFILE = 8'h03;
    localparam logic [3:0] RDCC_PROF_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Strap levels
    // ------------------------------------------------------------------
    localparam logic [2:0] RDCC_LVL_L0 = 3'h0;
    localparam logic [2:0] RDCC_LVL_L1 = 3'h1;
    localparam logic [2:0] RDCC_LVL_L2 = 3'h2;
    localparam logic [2:0] RDCC_LVL_L3 = 3'h3;
    localparam logic [2:0] RDCC_LVL_L4 = 3'h4;

    // Configuration word: {channel[4:0], kind[1:0], value[4:0]}
    localparam logic [1:0] RDCC_KIND_EQ = 2'h0;
    localparam logic [1:0] RDCC_KIND_GAIN = 2'h1;

    typedef enum logic [3:0] {
        RDCC_ST_STRAP = 4'b0001,
        RDCC_ST_LOAD = 4'b0010,
        RDCC_ST_TARGET = 4'b0100,
        RDCC_ST_RUN = 4'b1000
    } rdcc_state_t;

    typedef enum logic [2:0] {
        RDCC_MODE_PCIE = 3'b001,
        RDCC_MODE_BUFFER = 3'b010,
        RDCC_MODE_STANDBY = 3'b100
    } rdcc_mode_t;
endpackage : rdcc_pkg

// ===== design/rdcc_bank_sync.sv
// Power-down pin synchroniser and toggle detector for the lane banks
`timescale 1ns/100ps
module rdcc_bank_sync (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Pins
    input wire logic [rdcc_pkg::RDCC_BANKS-1:0] i_pin,
    // Results
    output logic [rdcc_pkg::RDCC_BANKS-1:0] o_level,
    output logic [rdcc_pkg::RDCC_BANKS-1:0] o_toggle
);
    import rdcc_pkg::*;

    logic [RDCC_BANKS-1:0] meta_r;
    logic [RDCC_BANKS-1:0] sync_r;
    logic [RDCC_BANKS-1:0] last_r;
    logic armed_r;
    wire [RDCC_BANKS-1:0] edge_w = (sync_r ^ last_r) & {RDCC_BANKS{armed_r}};

    // Meta stage feeds only the second stage
    always_ff @(posedge i_mclk) begin
        meta_r <= i_pin;
        sync_r <= meta_r;
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            last_r <= '0;
            armed_r <= 1'b0;
            o_level <= '0;
            o_toggle <= '0;
        end else begin
            last_r <= sync_r;
            armed_r <= 1'b1;
            o_level <= sync_r;
            o_toggle <= edge_w;
        end
    end
endmodule : rdcc_bank_sync

// ===== design/rdcc_top.sv
// Configuration and mode control of a 32-lane linear redriver
`timescale 1ns/100ps
module rdcc_top (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Strap inputs, already resolved to a level
    input wire logic [rdcc_pkg::RDCC_LVL_W-1:0] i_mode_strap,
    // Lane bank power-down pins
    input wire logic [rdcc_pkg::RDCC_BANKS-1:0] i_lane_bank_power_down,
    // EEPROM loader word stream
    input wire logic i_ee_valid,
    input wire logic [rdcc_pkg::RDCC_CFG_W-1:0] i_ee_word,
    input wire logic i_ee_last,
    input wire logic i_ee_error,
    // Target bus register writes
    input wire logic i_tgt_wr,
    input wire logic [rdcc_pkg::RDCC_CFG_W-1:0] i_tgt_word,
    input wire logic i_tgt_shared_wr,
    input wire logic [rdcc_pkg::RDCC_ADDR_W-1:0] i_tgt_shared_addr,
    input wire logic [rdcc_pkg::RDCC_PROF_W-1:0] i_tgt_shared_data,
    input wire logic i_pcie_sm_enable,
    input wire logic i_rxdet_write,
    // Status and controls
    output logic o_ee_read_en_n,
    output logic o_all_done_n,
    output logic o_ctrl_mode,
    output logic o_strap_bad,
    output logic o_cfg_reject,
    output logic [rdcc_pkg::RDCC_CHANNELS*rdcc_pkg::RDCC_EQ_W-1:0] o_boost_setting_index,
    output logic [rdcc_pkg::RDCC_CHANNELS*rdcc_pkg::RDCC_GAIN_W-1:0] o_flat_gain,
    output logic [rdcc_pkg::RDCC_PROF_W-1:0] o_eq_profile,
    output logic [rdcc_pkg::RDCC_BANKS-1:0] o_rxdet_start,
    output logic [rdcc_pkg::RDCC_BANKS*3-1:0] o_bank_mode,
    output logic [rdcc_pkg::RDCC_BANKS*rdcc_pkg::RDCC_BANK_LANES-1:0] o_lane_off
);
    import rdcc_pkg::*;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic eq_ok(input logic [RDCC_EQ_W-1:0] idx);
        eq_ok = (idx <= RDCC_EQ_MAX) && (idx != RDCC_EQ_HOLE_LO) && (idx != RDCC_EQ_HOLE_HI);
    endfunction : eq_ok

    function automatic logic gain_ok(input logic [RDCC_GAIN_W-1:0] g);
        gain_ok = (g == RDCC_GAIN_M6) || (g == RDCC_GAIN_M4) || (g == RDCC_GAIN_M2)
            || (g == RDCC_GAIN_0) || (g == RDCC_GAIN_P2);
    endfunction : gain_ok

    function automatic logic word_ok(input logic [RDCC_CFG_W-1:0] w);
        logic [1:0] kind;
        kind = w[6:5];
        if (kind == RDCC_KIND_EQ) begin
            word_ok = eq_ok(w[4:0]);
        end else if (kind == RDCC_KIND_GAIN) begin
            word_ok = gain_ok(w[2:0]);
        end else begin
            word_ok = 1'b0;
        end
    endfunction : word_ok

    function automatic logic thermo_ok(input logic [RDCC_PROF_W-1:0] t);
        thermo_ok = ((t + 4'h1) & t) == 4'h0;
    endfunction : thermo_ok

    // ------------------------------------------------------------------
    // Power-down pin crossing
    // ------------------------------------------------------------------
    logic [RDCC_BANKS-1:0] pd_level;
    logic [RDCC_BANKS-1:0] pd_toggle;

    rdcc_bank_sync u_sync (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_pin(i_lane_bank_power_down),
        .o_level(pd_level),
        .o_toggle(pd_toggle)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    rdcc_state_t state_r;
    rdcc_state_t state_nxt;
    logic ctrl_mode_r;
    logic boot_det_r;

    wire strap_ctrl = (i_mode_strap == RDCC_LVL_L1);
    wire strap_tgt = (i_mode_strap == RDCC_LVL_L2);
    wire ee_done = (state_r == RDCC_ST_LOAD) && i_ee_valid && i_ee_last && !i_ee_error;
    wire ee_fail = (state_r == RDCC_ST_LOAD) && i_ee_error;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            RDCC_ST_STRAP: begin
                state_nxt = strap_ctrl ? RDCC_ST_LOAD : RDCC_ST_TARGET;
            end
            RDCC_ST_LOAD: begin
                if (ee_done || ee_fail) begin
                    state_nxt = RDCC_ST_RUN;
                end
            end
            RDCC_ST_TARGET: begin
                state_nxt = RDCC_ST_TARGET;
            end
            RDCC_ST_RUN: begin
                state_nxt = RDCC_ST_RUN;
            end
        endcase
    end

    // Straps are caught once, in the first clocked cycle after reset
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            state_r <= RDCC_ST_STRAP;
            ctrl_mode_r <= 1'b0;
            o_strap_bad <= 1'b0;
            o_ee_read_en_n <= 1'b1;
            o_all_done_n <= 1'b1;
            boot_det_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            boot_det_r <= 1'b0;
            if (state_r == RDCC_ST_STRAP) begin
                ctrl_mode_r <= strap_ctrl;
                o_strap_bad <= !strap_ctrl && !strap_tgt;
                o_ee_read_en_n <= !strap_ctrl;
            end
            if (ee_done || ee_fail) begin
                o_ee_read_en_n <= 1'b1;
            end
            if (ee_done) begin
                o_all_done_n <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Configuration store
    // ------------------------------------------------------------------
    // Host writes win over a loader word in the same cycle; the host arbitrated
    wire ee_take = (state_r == RDCC_ST_LOAD) && i_ee_valid && !i_ee_error;
    wire tgt_take = i_tgt_wr && (state_r != RDCC_ST_STRAP);
    wire any_take = tgt_take || ee_take;
    wire [RDCC_CFG_W-1:0] cfg_word = tgt_take ? i_tgt_word : i_ee_word;
    wire cfg_good = word_ok(cfg_word);
    wire [4:0] cfg_chan = cfg_word[11:7];
    wire prof_wr = i_tgt_shared_wr && (i_tgt_shared_addr == RDCC_REG_EQ_PROFILE);
    wire prof_good = thermo_ok(i_tgt_shared_data);

    logic [RDCC_EQ_W-1:0] eq_r [RDCC_CHANNELS];
    logic [RDCC_GAIN_W-1:0] gain_r [RDCC_CHANNELS];

    genvar ch;
    generate
        for (ch = 0; ch < RDCC_CHANNELS; ch++) begin : g_ch
            wire hit = any_take && cfg_good && (cfg_chan == 5'(ch));
            always_ff @(posedge i_mclk) begin
                if (i_reset) begin
                    eq_r[ch] <= RDCC_EQ_DEFAULT;
                    gain_r[ch] <= RDCC_GAIN_RESET;
                end else if (hit && cfg_word[6:5] == RDCC_KIND_EQ) begin
                    eq_r[ch] <= cfg_word[4:0];
                end else if (hit) begin
                    gain_r[ch] <= cfg_word[2:0];
                end
            end
            assign o_boost_setting_index[ch*RDCC_EQ_W +: RDCC_EQ_W] = eq_r[ch];
            assign o_flat_gain[ch*RDCC_GAIN_W +: RDCC_GAIN_W] = gain_r[ch];
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_eq_profile <= RDCC_PROF_RESET;
            o_cfg_reject <= 1'b0;
            o_ctrl_mode <= 1'b0;
        end else begin
            o_ctrl_mode <= ctrl_mode_r;
            o_cfg_reject <= (any_take && !cfg_good) || (prof_wr && !prof_good);
            if (prof_wr && prof_good) begin
                o_eq_profile <= i_tgt_shared_data;
            end
        end
    end

    // ------------------------------------------------------------------
    // Receiver detect and bank modes
    // ------------------------------------------------------------------
    wire [RDCC_BANKS-1:0] det_w = pd_toggle | {RDCC_BANKS{boot_det_r | i_rxdet_write}};
    logic [RDCC_BANKS*3-1:0] mode_w;
    logic [RDCC_BANKS*RDCC_BANK_LANES-1:0] off_w;

    genvar bk;
    generate
        for (bk = 0; bk < RDCC_BANKS; bk++) begin : g_bk
            wire [2:0] m = pd_level[bk] ? 3'(RDCC_MODE_STANDBY)
                : (i_pcie_sm_enable ? 3'(RDCC_MODE_PCIE) : 3'(RDCC_MODE_BUFFER));
            assign mode_w[bk*3 +: 3] = m;
            assign off_w[bk*RDCC_BANK_LANES +: RDCC_BANK_LANES] =
                {RDCC_BANK_LANES{pd_level[bk]}};
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_rxdet_start <= '0;
            o_bank_mode <= '0;
            o_lane_off <= '0;
        end else begin
            o_rxdet_start <= det_w & {RDCC_BANKS{i_pcie_sm_enable}};
            o_bank_mode <= mode_w;
            o_lane_off <= off_w;
        end
    end
endmodule : rdcc_top

// ===== tb/rdcc_ee_model.sv
// Behavioural configuration store feeding the loader word stream
`timescale 1ns/100ps
module rdcc_ee_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Loader handshake
    input wire logic i_read_en_n,
    output logic o_valid,
    output logic [rdcc_pkg::RDCC_CFG_W-1:0] o_word,
    output logic o_last
);
    import rdcc_pkg::*;
    // Channel 5 index 7, channel 6 gain -4 dB, channel 7 index 19
    logic [11:0] rom [3] = '{12'h287, 12'h321, 12'h393};
    int n = 0;
    int gap = 0;
    initial begin
        o_valid = 0;
        o_word = '0;
        o_last = 0;
    end
    // Slow answer: idle gaps between words, and the word bus flips to the inverse of its last value between words
    always @(negedge i_mclk) begin
        gap = (i_reset || i_read_en_n || o_valid) ? 0 : gap + 1;
        if (i_reset) begin
            n = 0;
        end
        o_valid <= (gap == 4 && n < 3);
        o_last <= (gap == 4 && n == 2);
        o_word <= (gap == 4 && n < 3) ? rom[n] : ~o_word;
        if (gap == 4) begin
            n = n + 1;
        end
    end
endmodule : rdcc_ee_model

// ===== tb/rdcc_top_asserts.sv
// Checker of the configuration control block's port behaviour
`timescale 1ns/100ps
module rdcc_top_asserts (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // Inputs
    input wire logic [rdcc_pkg::RDCC_BANKS-1:0] i_lane_bank_power_down,
    input wire logic i_tgt_wr,
    input wire logic [rdcc_pkg::RDCC_CFG_W-1:0] i_tgt_word,
    input wire logic i_pcie_sm_enable,
    input wire logic i_rxdet_write,
    // Outputs
    input wire logic o_ee_read_en_n,
    input wire logic o_all_done_n,
    input wire logic o_ctrl_mode,
    input wire logic o_strap_bad,
    input wire logic o_cfg_reject,
    input wire logic [rdcc_pkg::RDCC_CHANNELS*rdcc_pkg::RDCC_EQ_W-1:0] o_boost_setting_index,
    input wire logic [rdcc_pkg::RDCC_BANKS-1:0] o_rxdet_start,
    input wire logic [rdcc_pkg::RDCC_BANKS*3-1:0] o_bank_mode,
    input wire logic [rdcc_pkg::RDCC_BANKS*rdcc_pkg::RDCC_BANK_LANES-1:0] o_lane_off
);
    import rdcc_pkg::*;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    property p_done_load; $fell(o_all_done_n) |-> $rose(o_ee_read_en_n); endproperty
    a_done_load: assert property (p_done_load) else $error("done without load end");
    property p_done_keep; !o_all_done_n |=> !o_all_done_n; endproperty
    a_done_keep: assert property (p_done_keep) else $error("done released");
    property p_ctrl_ok; o_ctrl_mode |-> !o_strap_bad; endproperty
    a_ctrl_ok: assert property (p_ctrl_ok) else $error("controller mode on bad strap");
    // The mode output lands two edges after release, so three clean edges guard the check
    property p_strap_once;
        !$past(i_reset) && !$past(i_reset, 2) && !$past(i_reset, 3) |-> $stable(o_ctrl_mode);
    endproperty
    a_strap_once: assert property (p_strap_once) else $error("strap resampled");
    property p_wr_eq;
        i_tgt_wr && i_tgt_word[11:5] == 7'h08 && i_tgt_word[4:0] <= 5'h13
        && i_tgt_word[4:0] != 5'h03 && i_tgt_word[4:0] != 5'h04
        |=> o_boost_setting_index[14:10] == $past(i_tgt_word[4:0]);
    endproperty
    a_wr_eq: assert property (p_wr_eq) else $error("index write lost");
    property p_rej_hold; o_cfg_reject |-> $stable(o_boost_setting_index); endproperty
    a_rej_hold: assert property (p_rej_hold) else $error("refused write took effect");
    property p_rx_write; i_rxdet_write && i_pcie_sm_enable |=> o_rxdet_start == 4'hF; endproperty
    a_rx_write: assert property (p_rx_write) else $error("no detect on write");
    property p_pd_trig;
        $changed(i_lane_bank_power_down[1]) && i_pcie_sm_enable |-> ##[1:4] o_rxdet_start[1];
    endproperty
    a_pd_trig: assert property (p_pd_trig) else $error("no detect on pin toggle");
    property p_standby; o_lane_off[8] |-> o_bank_mode[5:3] == 3'b100 && &o_lane_off[15:8]; endproperty
    a_standby: assert property (p_standby) else $error("bank not in standby");
    property p_lanes_on; o_bank_mode[5:3] != 3'b100 |-> o_lane_off[15:8] == 8'h00; endproperty
    a_lanes_on: assert property (p_lanes_on) else $error("active bank powered off");
endmodule : rdcc_top_asserts

// ===== tb/rdcc_top_tb_top.sv
// Self-checking testbench of the configuration control block
`timescale 1ns/100ps
module rdcc_top_tb_top;
    import rdcc_pkg::*;
    logic i_mclk = 0, i_reset = 1, i_tgt_wr = 0, sh_wr = 0, sm_en = 0, rxw = 0, ok, ee_err = 0;
    logic ee_v, ee_l, rd_n, done_n, ctrl, bad, rej;
    logic [2:0] i_mode_strap = 3'h1;
    logic [3:0] i_lane_bank_power_down = 4'h0, sd = 4'h0, prof, rx, seen, exp_p;
    logic [7:0] sa = 8'h00;
    logic [11:0] tw = 12'h000, ee_w, bmode;
    logic [159:0] eq;
    logic [95:0] gain;
    logic [31:0] loff;
    logic [4:0] exp_eq = RDCC_EQ_DEFAULT;
    logic [2:0] exp_g = RDCC_GAIN_RESET;
    logic [2:0] st [4] = '{RDCC_LVL_L2, RDCC_LVL_L4, RDCC_LVL_L1, RDCC_LVL_L1};
    int err_total = 0, checks_done = 0, cyc = 0;
    rdcc_top u_rdcc_top (.i_mclk(i_mclk), .i_reset(i_reset), .i_mode_strap(i_mode_strap),
        .i_lane_bank_power_down(i_lane_bank_power_down), .i_ee_valid(ee_v),
        .i_ee_word(ee_w), .i_ee_last(ee_l), .i_ee_error(ee_err), .i_tgt_wr(i_tgt_wr),
        .i_tgt_word(tw), .i_tgt_shared_wr(sh_wr), .i_tgt_shared_addr(sa),
        .i_tgt_shared_data(sd), .i_pcie_sm_enable(sm_en), .i_rxdet_write(rxw),
        .o_ee_read_en_n(rd_n), .o_all_done_n(done_n), .o_ctrl_mode(ctrl),
        .o_strap_bad(bad), .o_cfg_reject(rej), .o_boost_setting_index(eq), .o_flat_gain(gain),
        .o_eq_profile(prof), .o_rxdet_start(rx), .o_bank_mode(bmode), .o_lane_off(loff));
    rdcc_ee_model u_rdcc_ee_model (.i_mclk(i_mclk), .i_reset(i_reset), .i_read_en_n(rd_n),
        .o_valid(ee_v), .o_word(ee_w), .o_last(ee_l));
    initial begin
        forever #2.5 i_mclk = ~i_mclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wr_cfg(input logic [11:0] w);
        @(negedge i_mclk);
        i_tgt_wr = 1;
        tw = w;
        @(negedge i_mclk);
        i_tgt_wr = 0;
    endtask : wr_cfg
    task automatic wr_prof(input logic [7:0] a, input logic [3:0] d);
        @(negedge i_mclk);
        sh_wr = 1;
        sa = a;
        sd = d;
        @(negedge i_mclk);
        sh_wr = 0;
    endtask : wr_prof
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        // Controller strap last, so its load is the one exercised below
        for (int k = 0; k < 4; k++) begin
            @(negedge i_mclk);
            i_reset = 1;
            i_mode_strap = st[k];
            sm_en = (k == 3);
            repeat (3) @(negedge i_mclk);
            i_reset = 0;
            @(negedge i_mclk);
            chk(rx, {4{k == 3}});
            @(negedge i_mclk);
            chk(rd_n, k < 2);
            i_mode_strap = RDCC_LVL_L0;
            repeat (2) @(negedge i_mclk);
            chk(ctrl, k >= 2);
            chk(bad, k == 1);
            chk(eq[4:0], RDCC_EQ_DEFAULT);
            chk(gain[2:0], RDCC_GAIN_RESET);
            if (k == 0) begin
                wr_cfg({5'h04, RDCC_KIND_EQ, 5'h09});
                chk(eq[24:20], 5'h09);
            end
            // An aborted load must end the fetch without claiming success
            if (k == 2) begin
                ee_err = 1;
                @(negedge i_mclk);
                ee_err = 0;
                chk({done_n, rd_n}, 2'b11);
            end
        end
        // Host stays off the bus until the load ends
        for (int c = 0; c < 100 && done_n !== 1'b0; c++) @(negedge i_mclk);
        chk(done_n, 0);
        chk(rd_n, 1);
        chk({eq[29:25], gain[20:18], eq[39:35]}, {5'h07, RDCC_GAIN_M4, 5'h13});
        $display("test straps and load done");
        for (int v = 0; v < 32; v++) begin
            wr_cfg({5'h02, RDCC_KIND_EQ, v[4:0]});
            ok = !(v == 3 || v == 4 || v > 19);
            exp_eq = ok ? v[4:0] : exp_eq;
            chk({rej, eq[14:10]}, {!ok, exp_eq});
        end
        for (int v = 0; v < 8; v++) begin
            wr_cfg({5'h01, RDCC_KIND_GAIN, 2'h0, v[2:0]});
            ok = v[0] || v == 0;
            exp_g = ok ? v[2:0] : exp_g;
            chk({rej, gain[5:3]}, {!ok, exp_g});
        end
        wr_cfg({5'h01, 2'h2, 5'h05});
        chk({rej, eq[9:5], eq[19:15]}, {1'b1, RDCC_EQ_DEFAULT, RDCC_EQ_DEFAULT});
        exp_p = RDCC_PROF_RESET;
        for (int v = 0; v < 16; v++) begin
            wr_prof(RDCC_REG_EQ_PROFILE, v[3:0]);
            ok = (v & (v + 1)) == 0;
            exp_p = ok ? v[3:0] : exp_p;
            chk({rej, prof}, {!ok, exp_p});
        end
        wr_prof(8'h04, 4'h1);
        chk(prof, exp_p);
        $display("test settings done");
        sm_en = 1;
        @(negedge i_mclk);
        rxw = 1;
        @(negedge i_mclk);
        rxw = 0;
        chk(rx, 4'hF);
        for (int p = 0; p < 2; p++) begin
            i_lane_bank_power_down = {2'b00, ~p[0], 1'b0};
            seen = 4'h0;
            repeat (9) @(negedge i_mclk) seen = seen | rx;
            chk(seen, 4'h2);
            chk(loff, p ? 32'h0000_0000 : 32'h0000_FF00);
            chk(bmode[5:0], p ? 6'h09 : 6'h21);
        end
        sm_en = 0;
        repeat (4) @(negedge i_mclk);
        chk(bmode[2:0], 3'b010);
        $display("test modes done");
        tally_and_finish();
    end
endmodule : rdcc_top_tb_top
bind rdcc_top rdcc_top_asserts u_rdcc_top_asserts (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_lane_bank_power_down(i_lane_bank_power_down), .i_tgt_wr(i_tgt_wr),
    .i_tgt_word(i_tgt_word), .i_pcie_sm_enable(i_pcie_sm_enable),
    .i_rxdet_write(i_rxdet_write), .o_ee_read_en_n(o_ee_read_en_n),
    .o_all_done_n(o_all_done_n), .o_ctrl_mode(o_ctrl_mode), .o_strap_bad(o_strap_bad),
    .o_cfg_reject(o_cfg_reject), .o_boost_setting_index(o_boost_setting_index), .o_rxdet_start(o_rxdet_start),
    .o_bank_mode(o_bank_mode), .o_lane_off(o_lane_off));
